// ==== rtl/acx_pkg.sv ====
// Purpose: Shared constants and types of the auxiliary command engine
// Assumes: 100 MHz register clock, 1 MHz auxiliary sample tick
// Notes: Offsets are byte addresses on the register port
package acx_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [11:0] CMD_OFS = 12'h100;
	localparam logic [11:0] WFIFO_OFS = 12'h104;
	localparam logic [11:0] ADDR_OFS = 12'h108;
	localparam logic [11:0] DIV_OFS = 12'h10C;
	localparam logic [11:0] RDATA_OFS = 12'h134;
	localparam logic [11:0] RCODE_OFS = 12'h138;
	localparam logic [11:0] STATUS_OFS = 12'h140;

	// ****************************************
	// Command register fields
	// ****************************************
	localparam int LEN_LSB = 0;
	localparam int LEN_W = 4;
	localparam int OP_LSB = 8;
	localparam int OP_W = 4;
	localparam int CONT_BIT = 10;
	localparam int ONLY_BIT = 12;
	localparam int CMD_W = 13;
	localparam int ADDR_W = 20;
	localparam logic [3:0] OP_NATIVE_WR = 4'h8;
	localparam logic [3:0] OP_NATIVE_RD = 4'h9;
	localparam logic [1:0] I2C_KIND_WR = 2'h0;
	localparam logic [1:0] I2C_KIND_RD = 2'h1;
	localparam logic [1:0] I2C_KIND_WSTAT = 2'h2;

	// ****************************************
	// Status bits, reset values, timing
	// ****************************************
	localparam int STAT_REPLY = 0;
	localparam int STAT_TIMEOUT = 1;
	localparam int STAT_BUSY = 2;
	localparam logic [7:0] DIV_RESET = 8'h64;
	localparam logic [3:0] ACK_CODE = 4'h0;
	localparam int REPLY_DEPTH = 16;
	localparam int WRITE_DEPTH = 16;
	localparam int REPLY_TIMEOUT_US = 400;
	localparam int TICK_PER_US = 1;
	localparam logic [2:0] HDR_LAST = 3'h2;
	localparam logic [2:0] LEN_IDX = 3'h3;

	typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT, ST_RECV} acx_state_t;
endpackage

// ==== rtl/acx_fifo_if.sv ====
// Purpose: Carrier between the engine and a byte store
// Assumes: Single clock
// Notes: Owner pushes and pops, store answers
`timescale 1ns/1ps
interface acx_fifo_if #(parameter int W = 8);
	logic push;
	logic [W-1:0] push_data;
	logic pop;
	logic [W-1:0] pop_data;
	logic flush;
	logic full;
	logic empty;
	modport owner (output push, push_data, pop, flush, input pop_data, full, empty);
	modport store (input push, push_data, pop, flush, output pop_data, full, empty);
endinterface // acx_fifo_if

// ==== rtl/acx_byte_fifo.sv ====
// Purpose: Small first-in first-out byte store with flush
// Assumes: Depth is a power of two
// Notes: Push when full and pop when empty are ignored
`timescale 1ns/1ps
module acx_byte_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Owner side
	acx_fifo_if.store port
);
	localparam int AW = $clog2(DEPTH);

	// Depth check
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("acx_byte_fifo depth must be a power of two");
	end

	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic do_push, do_pop;

	// Flags and read data
	assign port.full = (wr_ptr ^ rd_ptr) == {1'b1, {AW{1'b0}}};
	assign port.empty = wr_ptr == rd_ptr;
	assign port.pop_data = mem[rd_ptr[AW-1:0]];
	assign do_push = port.push && !port.full && !port.flush;
	assign do_pop = port.pop && !port.empty && !port.flush;

	// Pointer next values
	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		if (port.flush) begin
			next_wr_ptr = '0;
			next_rd_ptr = '0;
		end else begin
			if (do_push) next_wr_ptr = wr_ptr + 1'b1;
			if (do_pop) next_rd_ptr = rd_ptr + 1'b1;
		end
	end

	// Pointer registers
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end

	// Storage
	always_ff @(posedge clock) begin
		if (do_push) mem[wr_ptr[AW-1:0]] <= port.push_data;
	end
endmodule // acx_byte_fifo

// ==== rtl/acx_tick_gen.sv ====
// Purpose: Divides the register clock down to the 1 MHz sample tick
// Assumes: Divide value equals the clock rate in MHz
// Notes: A divide value of zero behaves as one
`timescale 1ns/1ps
module acx_tick_gen (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Control
	input wire logic [7:0] div,
	output logic tick
);
	logic [7:0] cnt, next_cnt;
	logic next_tick;

	// Count to divide value minus one
	always_comb begin
		next_cnt = cnt + 8'h01;
		next_tick = 1'b0;
		if (cnt + 8'h01 >= div) begin
			next_cnt = 8'h00;
			next_tick = 1'b1;
		end
	end

	// Counter registers
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= 8'h00;
			tick <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick <= next_tick;
		end
	end
endmodule // acx_tick_gen

// ==== rtl/acx_engine.sv ====
// Purpose: Auxiliary channel request engine driven by register writes
// Assumes: Register strobes and link bytes synchronous to clock
// Notes: Request bytes go out on tx, reply bytes come in on rx
//
// Notes on behaviour
// [RQ1] Only a write to the command register launches a transaction.
// [RQ2] Host loads address, then write bytes, then command 0x08 for a write.
// [RQ3] Each launch ends in a reply-received or a reply-timeout flag; the timeout runs only while waiting for the first reply byte.
// [RQ4] Reply code register holds the sink code; zero means acknowledged.
// [RQ5] Host writes address first, then command with byte count for a read.
// [RQ6] Command bits 3..0 hold the payload length of reads and writes.
// [RQ7] Reply bytes are kept in a sixteen-entry byte store at one address.
// [RQ8] Each read of reply data returns the next byte and advances.
// [RQ9] Command bits 11..8 select the I2C write, read and status commands.
// [RQ10] Continuation bit set leaves the remote I2C bus in its state.
// [RQ11] Continuation bit clear makes the remote bus idle after the command.
// [RQ12] Bit 12 with I2C write or read gives an address-only request.
// [RQ13] Address-only requests carry no length and no data bytes.
// [RQ14] Bit 12 with write status sends a length-free progress query.
// [RQ15] Sink may answer a write with acknowledge plus bytes-written count.
// [RQ16] Host tolerates repeated defer codes and reissues commands.
// [RQ17] Host places I2C write bytes in the write store before commanding.
// [RQ18] Sink turns address-only write with continuation into start and address.
// [RQ19] Sink appends to an open write to the same address without a start.
// [RQ20] Sink ends a write without continuation with a stop.
// [RQ21] Sink turns address-only without continuation into just a stop.
// [RQ22] Software sets the divider to clock MHz for a 1 MHz sample tick.
// [RQ23] Host writes no control register until the reply flag is set.
// [RQ24] The reply store is emptied when a new transaction starts.
`timescale 1ns/1ps
module acx_engine #(
	parameter int REPLY_DEPTH = acx_pkg::REPLY_DEPTH,
	parameter int WRITE_DEPTH = acx_pkg::WRITE_DEPTH,
	parameter int TIMEOUT_US = acx_pkg::REPLY_TIMEOUT_US
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	// Link request bytes
	output logic aux_tick,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	input wire logic tx_ready,
	// Link reply bytes
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_last,
	// Status
	output logic busy
);
	localparam int TO_TICKS = TIMEOUT_US * acx_pkg::TICK_PER_US;

	// Parameter check
	if (TO_TICKS < 1 || TO_TICKS > 4095 || REPLY_DEPTH < 16) begin : g_bad_param
		$error("acx_engine timeout or reply depth out of range");
	end

	// ****************************************
	// Storage and divider
	// ****************************************
	acx_fifo_if #(.W(8)) wq ();
	acx_fifo_if #(.W(8)) rq ();

	acx_byte_fifo #(.W(8), .DEPTH(WRITE_DEPTH)) u_wfifo (
		.clock(clock),
		.sys_rst(sys_rst),
		.port(wq)
	);

	acx_byte_fifo #(.W(8), .DEPTH(REPLY_DEPTH)) u_rfifo ( // [RQ7]
		.clock(clock),
		.sys_rst(sys_rst),
		.port(rq)
	);

	logic [7:0] div;
	acx_tick_gen u_tick (
		.clock(clock),
		.sys_rst(sys_rst),
		.div(div),
		.tick(aux_tick) // [RQ22]
	);

	// ****************************************
	// State
	// ****************************************
	acx_pkg::acx_state_t state, next_state;
	logic [acx_pkg::CMD_W-1:0] cmd, next_cmd;
	logic [acx_pkg::ADDR_W-1:0] addr, next_addr;
	logic [7:0] next_div;
	logic [3:0] code, next_code;
	logic got_reply, next_got_reply;
	logic got_timeout, next_got_timeout;
	logic [4:0] idx, next_idx;
	logic [11:0] wait_cnt, next_wait_cnt;
	logic [31:0] next_rdata;

	// Decoded command
	logic [3:0] op;
	logic is_i2c, short_req, has_data;
	logic [4:0] last_idx;
	logic wr_hit, rd_hit, launch, tx_take;
	logic done_ok, done_to;

	// Decode address strobes
	function automatic logic hit(input logic stb, input logic [11:0] a, input logic [11:0] ofs);
		return stb && (a == ofs);
	endfunction

	// Command decode
	assign op = cmd[acx_pkg::OP_LSB +: acx_pkg::OP_W]; // [RQ9]
	assign is_i2c = !op[3];
	assign short_req = is_i2c && cmd[acx_pkg::ONLY_BIT]; // [RQ12] [RQ14]
	assign has_data = !short_req && (op == acx_pkg::OP_NATIVE_WR
		|| (is_i2c && op[1:0] == acx_pkg::I2C_KIND_WR));
	always_comb begin
		if (short_req) last_idx = {2'b00, acx_pkg::HDR_LAST}; // [RQ13]
		else if (has_data) last_idx = 5'(acx_pkg::LEN_IDX)
			+ 5'(cmd[acx_pkg::LEN_LSB +: acx_pkg::LEN_W]) + 5'h01; // [RQ6]
		else last_idx = {2'b00, acx_pkg::LEN_IDX};
	end

	assign launch = hit(reg_wr, reg_addr, acx_pkg::CMD_OFS) && state == acx_pkg::ST_IDLE; // [RQ1]
	assign tx_take = tx_valid && tx_ready;
	assign busy = state != acx_pkg::ST_IDLE;

	// ****************************************
	// Request byte builder
	// ****************************************
	// Header, address, length, then payload
	always_comb begin
		tx_valid = state == acx_pkg::ST_SEND;
		tx_last = idx == last_idx;
		unique case (idx)
			5'h00: tx_data = {op, addr[19:16]}; // [RQ10] [RQ11]
			5'h01: tx_data = addr[15:8];
			5'h02: tx_data = addr[7:0];
			5'h03: tx_data = {4'h0, cmd[acx_pkg::LEN_LSB +: acx_pkg::LEN_W]}; // [RQ6]
			default: tx_data = wq.empty ? 8'h00 : wq.pop_data;
		endcase
	end

	// Write store hookup
	assign wr_hit = hit(reg_wr, reg_addr, acx_pkg::WFIFO_OFS);
	assign wq.push = wr_hit;
	assign wq.push_data = reg_wdata[7:0];
	assign wq.pop = tx_take && idx > 5'(acx_pkg::LEN_IDX);
	assign wq.flush = 1'b0;

	// Reply store hookup
	assign rd_hit = hit(reg_rd, reg_addr, acx_pkg::RDATA_OFS);
	assign rq.flush = launch; // [RQ24]
	assign rq.push = state == acx_pkg::ST_RECV && rx_valid; // [RQ15]
	assign rq.push_data = rx_data;
	assign rq.pop = rd_hit; // [RQ8]

	// ****************************************
	// Transaction sequencer
	// ****************************************
	// Next state of the transaction
	always_comb begin
		next_state = state;
		next_idx = idx;
		next_wait_cnt = wait_cnt;
		next_code = code;
		done_ok = 1'b0;
		done_to = 1'b0;
		unique case (state)
			acx_pkg::ST_IDLE: begin
				if (launch) begin
					next_state = acx_pkg::ST_SEND;
					next_idx = 5'h00;
				end
			end
			acx_pkg::ST_SEND: begin
				if (tx_take) begin
					next_idx = idx + 5'h01;
					if (tx_last) begin
						next_state = acx_pkg::ST_WAIT;
						next_wait_cnt = 12'h000;
					end
				end
			end
			acx_pkg::ST_WAIT: begin
				if (rx_valid) begin
					next_code = rx_data[7:4]; // [RQ4]
					if (rx_last) done_ok = 1'b1;
					else next_state = acx_pkg::ST_RECV;
				end else if (aux_tick) begin
					next_wait_cnt = wait_cnt + 12'h001;
					if (wait_cnt + 12'h001 >= 12'(TO_TICKS)) done_to = 1'b1; // [RQ3]
				end
			end
			acx_pkg::ST_RECV: begin
				if (rx_valid && rx_last) done_ok = 1'b1;
			end
		endcase
		if (done_ok || done_to) next_state = acx_pkg::ST_IDLE;
		// Flags: a new event wins over a status read clear
		next_got_reply = got_reply;
		next_got_timeout = got_timeout;
		if (hit(reg_rd, reg_addr, acx_pkg::STATUS_OFS)) begin
			next_got_reply = 1'b0;
			next_got_timeout = 1'b0;
		end
		if (launch) begin
			next_got_reply = 1'b0;
			next_got_timeout = 1'b0;
		end
		if (done_ok) next_got_reply = 1'b1; // [RQ3]
		if (done_to) next_got_timeout = 1'b1; // [RQ3]
	end

	// Sequencer registers
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state <= acx_pkg::ST_IDLE;
			idx <= 5'h00;
			wait_cnt <= 12'h000;
			code <= acx_pkg::ACK_CODE;
			got_reply <= 1'b0;
			got_timeout <= 1'b0;
		end else begin
			state <= next_state;
			idx <= next_idx;
			wait_cnt <= next_wait_cnt;
			code <= next_code;
			got_reply <= next_got_reply;
			got_timeout <= next_got_timeout;
		end
	end

	// ****************************************
	// Control registers and read port
	// ****************************************
	// Next control values; writes while busy are ignored
	always_comb begin
		next_cmd = cmd;
		next_addr = addr;
		next_div = div;
		if (launch) next_cmd = reg_wdata[acx_pkg::CMD_W-1:0]; // [RQ1]
		if (hit(reg_wr, reg_addr, acx_pkg::ADDR_OFS) && !busy) begin
			next_addr = reg_wdata[acx_pkg::ADDR_W-1:0];
		end
		if (hit(reg_wr, reg_addr, acx_pkg::DIV_OFS) && !busy) begin
			next_div = reg_wdata[7:0]; // [RQ22]
		end
	end

	// Read data mux, registered
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				acx_pkg::CMD_OFS: next_rdata = {19'h0, cmd};
				acx_pkg::ADDR_OFS: next_rdata = {12'h000, addr};
				acx_pkg::DIV_OFS: next_rdata = {24'h0, div};
				acx_pkg::RDATA_OFS: next_rdata = {24'h0, rq.empty ? 8'h00 : rq.pop_data}; // [RQ8]
				acx_pkg::RCODE_OFS: next_rdata = {28'h0, code}; // [RQ4]
				acx_pkg::STATUS_OFS: begin
					next_rdata[acx_pkg::STAT_REPLY] = got_reply;
					next_rdata[acx_pkg::STAT_TIMEOUT] = got_timeout;
					next_rdata[acx_pkg::STAT_BUSY] = busy;
				end
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// Control registers
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cmd <= '0;
			addr <= '0;
			div <= acx_pkg::DIV_RESET;
			reg_rdata <= 32'h0000_0000;
		end else begin
			cmd <= next_cmd;
			addr <= next_addr;
			div <= next_div;
			reg_rdata <= next_rdata;
		end
	end
endmodule // acx_engine

// ==== test/acx_engine_props.sv ====
// Purpose: Port-level checks of the auxiliary command engine
// Assumes: One clock domain, reset active high
// Notes: Attached by bind below the module
`timescale 1ns/1ps
module acx_engine_props #(
	parameter int TIMEOUT_US = 400
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	// Link side
	input wire logic aux_tick,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	input wire logic tx_ready,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_last,
	// Status
	input wire logic busy
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	// Command write while idle
	sequence launch_s;
		reg_wr && reg_addr == acx_pkg::CMD_OFS && !busy;
	endsequence
	// First request byte carries the opcode
	sequence first_s;
		busy && tx_valid && tx_data[7:4] == $past(reg_wdata[11:8]);
	endsequence
	launch_busy_a: assert property (launch_s |=> first_s) else $error("launch missing");
	quiet_idle_a: assert property (!busy && !(reg_wr && reg_addr == acx_pkg::CMD_OFS) |=> !busy)
		else $error("start without command");
	idle_tx_a: assert property (!busy |-> !tx_valid) else $error("request byte while idle");
	tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
		&& $stable(tx_last)) else $error("request byte changed unaccepted");
	tx_end_a: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
		else $error("byte after last");
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("rdata not zero");
	reply_done_a: assert property (busy && rx_valid && rx_last |-> ##[1:2] !busy)
		else $error("reply not closed");
	status_hi_a: assert property (reg_rd && reg_addr == acx_pkg::STATUS_OFS |=>
		reg_rdata[31:3] == 29'h0) else $error("status upper bits set");
	tick_gap_a: assert property (aux_tick |=> !aux_tick ##[0:299] aux_tick)
		else $error("tick spacing");
endmodule // acx_engine_props

bind acx_engine acx_engine_props #(.TIMEOUT_US(TIMEOUT_US)) u_props (.clock(clock),
	.sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .aux_tick(aux_tick), .tx_valid(tx_valid),
	.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid),
	.rx_data(rx_data), .rx_last(rx_last), .busy(busy));

// ==== test/acx_sink_model.sv ====
// Purpose: Behavioural sink answering link requests
// Assumes: Reply follows the last request byte
// Notes: Idle data line toggles so stale values never look valid
`timescale 1ns/1ps
module acx_sink_model (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Request side
	input wire logic tx_valid,
	input wire logic tx_last,
	output logic tx_ready,
	// Reply side
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_last,
	// Scenario control
	input wire logic [3:0] rep_code,
	input wire logic [4:0] rep_n,
	input wire logic silent,
	input wire logic slow
);
	// ****************************************
	// Reply sequencer
	// ****************************************
	logic [1:0] ph;
	logic [4:0] cnt;
	// Collect request, then send code byte and data bytes
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ph <= 2'h0;
			cnt <= 5'h00;
			tx_ready <= 1'b0;
			rx_valid <= 1'b0;
			rx_last <= 1'b0;
			rx_data <= 8'h00;
		end else begin
			tx_ready <= slow ? ~tx_ready : 1'b1;
			rx_valid <= 1'b0;
			rx_last <= 1'b0;
			rx_data <= ~rx_data;
			if (ph == 2'h0 && tx_valid && tx_ready && tx_last && !silent) begin
				ph <= 2'h1;
			end else if (ph == 2'h1) begin
				rx_valid <= 1'b1;
				rx_data <= {rep_code, 4'h0}; // Defer or acknowledge code
				rx_last <= (rep_n == 5'h00);
				cnt <= 5'h01;
				ph <= (rep_n == 5'h00) ? 2'h0 : 2'h2;
			end else if (ph == 2'h2) begin
				rx_valid <= 1'b1;
				rx_data <= 8'hA0 + {3'h0, cnt} - 8'h01; // Count byte first
				rx_last <= (cnt == rep_n);
				cnt <= cnt + 5'h01;
				if (cnt == rep_n) begin
					ph <= 2'h0;
				end
			end
		end
	end
endmodule // acx_sink_model

// ==== test/tb_acx_engine.sv ====
// Purpose: Register-level tests of the auxiliary command engine
// Assumes: Sink model on the link side
// Notes: Divider set to 2 and a short timeout keep the run brief
`timescale 1ns/1ps
module tb_acx_engine;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic clock, sys_rst, reg_wr, reg_rd, aux_tick, tx_valid, tx_last, tx_ready;
	logic rx_valid, rx_last, busy, silent, slow;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [7:0] tx_data, rx_data;
	logic [3:0] rep_code;
	logic [4:0] rep_n;
	logic [7:0] req [32];
	int req_n, err_count, tests_run, i;
	logic [31:0] icmd [8] = '{32'h1000, 32'h1400, 32'h1100, 32'h1500, 32'h1200, 32'h1600,
		32'h0400, 32'h0501};
	int ilen [8] = '{3, 3, 3, 3, 3, 3, 5, 4};
	acx_engine #(.TIMEOUT_US(5)) uut (.clock(clock), .sys_rst(sys_rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.aux_tick(aux_tick), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
		.busy(busy));
	acx_sink_model sink (.clock(clock), .sys_rst(sys_rst), .tx_valid(tx_valid),
		.tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_last(rx_last), .rep_code(rep_code), .rep_n(rep_n), .silent(silent), .slow(slow));
	// Clock and request byte capture
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		if (tx_valid && tx_ready) begin
			req[req_n[4:0]] <= tx_data;
			req_n <= req_n + 1;
		end
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(negedge clock);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = v;
		@(negedge clock);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] v);
		@(negedge clock);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clock);
		reg_rd = 1'b0;
		v = reg_rdata;
	endtask
	// Launch, wait bounded for idle, check byte count and status
	task automatic run(input logic [31:0] cmd, input int n, input logic [3:0] code,
		input logic [4:0] rn, input logic [31:0] st);
		int k;
		logic [31:0] s;
		rep_code = code;
		rep_n = rn;
		req_n = 0;
		wr(acx_pkg::CMD_OFS, cmd);
		k = 0;
		while (busy !== 1'b0 && k < 2000) begin // No control writes while busy
			@(negedge clock);
			k++;
		end
		chk("idle", 32'h0, {31'h0, busy});
		chk("request bytes", 32'(n), 32'(req_n));
		rd(acx_pkg::STATUS_OFS, s);
		chk("status", st, s);
	endtask
	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ****************************************
	// Sequence and watchdog
	// ****************************************
	initial begin
		#300000;
		err_count++;
		report_and_stop;
	end
	initial begin
		{reg_wr, reg_rd, silent, slow, req_n, err_count, tests_run} = '0;
		{reg_addr, reg_wdata, rep_code, rep_n} = '0;
		sys_rst = 1'b1;
		repeat (12) @(posedge clock);
		@(negedge clock);
		sys_rst = 1'b0;
		rd(12'h000, d);
		chk("unmapped", 32'h0, d);
		rd(acx_pkg::DIV_OFS, d);
		chk("divider", 32'h64, d);
		wr(acx_pkg::DIV_OFS, 32'h2);
		wr(acx_pkg::ADDR_OFS, 32'h12345);
		for (i = 1; i < 4; i++) begin
			wr(acx_pkg::WFIFO_OFS, 32'h11 * 32'(i));
		end
		run(32'h802, 7, 4'h0, 5'd0, 32'h1);
		chk("wr head", 32'h81234502, {req[0], req[1], req[2], req[3]});
		chk("wr data", 32'h112233, {8'h0, req[4], req[5], req[6]});
		rd(acx_pkg::RCODE_OFS, d);
		chk("code", 32'h0, d);
		wr(acx_pkg::ADDR_OFS, 32'h50);
		for (i = 0; i < 8; i++) begin
			wr(acx_pkg::WFIFO_OFS, 32'h5A);
			run(icmd[i], ilen[i], 4'(2 * (i % 2)), 5'd1, 32'h1);
			chk("i2c head", {8'h0, icmd[i][11:8], 20'h00050}, {8'h0, req[0], req[1], req[2]});
			rd(acx_pkg::RCODE_OFS, d);
			chk("i2c code", 32'(2 * (i % 2)), d);
			rd(acx_pkg::RDATA_OFS, d);
			chk("count byte", 32'hA0, d);
		end
		slow = 1'b1;
		run(32'h90F, 4, 4'h0, 5'd17, 32'h1);
		for (i = 0; i < 17; i++) begin
			rd(acx_pkg::RDATA_OFS, d);
			chk("rdata", (i < 16) ? 32'hA0 + 32'(i) : 32'h0, d);
		end
		run(32'h901, 4, 4'h0, 5'd2, 32'h1);
		rd(acx_pkg::RDATA_OFS, d);
		run(32'h900, 4, 4'h0, 5'd0, 32'h1);
		rd(acx_pkg::RDATA_OFS, d);
		chk("flushed", 32'h0, d);
		silent = 1'b1;
		run(32'h900, 4, 4'h0, 5'd0, 32'h2);
		rd(acx_pkg::STATUS_OFS, d);
		chk("status clear", 32'h0, d);
		report_and_stop;
	end
endmodule // tb_acx_engine
